// *** logic/pfc_cfg.svh ***
// constants for the parallel flash command controller
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH
// ---------------------------------------------------------------
// register offsets (byte addresses on the apb side)
// ---------------------------------------------------------------
`define PFC_OFF_CTRL 12'h000
`define PFC_OFF_ADDR 12'h004
`define PFC_OFF_DATA 12'h008
`define PFC_OFF_STAT 12'h00C
`define PFC_OFF_RDAT 12'h010
// ---------------------------------------------------------------
// control fields: op code in [2:0], go bit at 31
// ---------------------------------------------------------------
`define PFC_CTRL_OP_LSB 0
`define PFC_CTRL_GO_BIT 31
`define PFC_CTRL_HV_BIT 8
// ---------------------------------------------------------------
// status fields
// ---------------------------------------------------------------
`define PFC_STAT_BUSY_BIT 0
`define PFC_STAT_DONE_BIT 1
`define PFC_STAT_ERR_BIT 2
// ---------------------------------------------------------------
// flash command bytes and unlock addresses
// ---------------------------------------------------------------
`define PFC_UNLOCK_A1 19'h05555
`define PFC_UNLOCK_A2 19'h02AAA
`define PFC_UNLOCK_D1 8'hAA
`define PFC_UNLOCK_D2 8'h55
`define PFC_CMD_RESET 8'hF0
`define PFC_CMD_AUTOSEL 8'h90
`define PFC_CMD_PROGRAM 8'hA0
`define PFC_CMD_ERASE 8'h80
`define PFC_CMD_CHIP 8'h10
`define PFC_CMD_SECTOR 8'h30
// ---------------------------------------------------------------
// bus timing in ns and derived cycle counts at 40 MHz
// ---------------------------------------------------------------
`define PFC_CLK_NS 25
`define PFC_STROBE_NS 100
`define PFC_STROBE_CYC ((`PFC_STROBE_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_POLL_BIT 7
`define PFC_TOGGLE_BIT 6
`define PFC_MAX_POLLS 16'hFFFF
`endif

// *** logic/pfc_pkg.sv ***
// types for the parallel flash command controller
package pfc_pkg;
   // high level operations requested by software
   typedef enum logic [2:0]
   {
      PFC_OP_READ, PFC_OP_RESET, PFC_OP_IDREAD, PFC_OP_PROGRAM,
      PFC_OP_CHIPERASE, PFC_OP_SECTERASE, PFC_OP_ADDSECTOR
   } pfc_op_t;
   // pin strobe sequencer states
   typedef enum logic [2:0]
   {
      PFC_CY_IDLE, PFC_CY_SETUP, PFC_CY_STROBE, PFC_CY_HOLD
   } pfc_cy_t;
   // command walker states
   typedef enum logic [2:0]
   {
      PFC_SQ_IDLE, PFC_SQ_ISSUE, PFC_SQ_WAIT, PFC_SQ_POLL, PFC_SQ_PWAIT
   } pfc_sq_t;
endpackage

// *** logic/pfc_bus_cycle.sv ***
// one read or write cycle on the flash pins
`timescale 1ns/1ps
`include "pfc_cfg.svh"
module pfc_bus_cycle
(
   input wire logic clock,
   input wire logic reset,
   input wire logic clockEnable,
   input wire logic start,
   input wire logic isWrite,
   input wire logic [18:0] addrIn,
   input wire logic [7:0] dataIn,
   input wire logic [7:0] byteLinesIn,
   output logic busy,
   output logic done,
   output logic [7:0] readByte,
   output logic chipSelectN,
   output logic outGateN,
   output logic writeStrobeN,
   output logic [18:0] address,
   output logic [7:0] byteLinesOut,
   output logic byteLinesOe
);
   // all state of the cycle engine
   typedef struct packed
   {
      pfc_pkg::pfc_cy_t st;
      logic [3:0] cnt;
      logic wr;
      logic done;
      logic [7:0] rd;
      logic cs;
      logic oe;
      logic we;
      logic [18:0] a;
      logic [7:0] d;
      logic ben;
   } pfc_cy_s_t;
   pfc_cy_s_t cur;
   pfc_cy_s_t next_cur;
   // strobe width in cycles, always at least one
   localparam logic [3:0] STROBE = 4'(`PFC_STROBE_CYC);
   // next state: address set up before strobe, data held past it
   always_comb
   begin
      next_cur = cur;
      next_cur.done = 1'b0;
      case (cur.st)
         pfc_pkg::PFC_CY_IDLE:
         begin
            if (start)
            begin
               next_cur.st = pfc_pkg::PFC_CY_SETUP;
               next_cur.wr = isWrite;
               next_cur.a = addrIn;
               next_cur.d = dataIn;
               next_cur.cs = 1'b0;
               // drive lines only on a write, so no contention
               next_cur.ben = isWrite;
            end
         end
         pfc_pkg::PFC_CY_SETUP:
         begin
            next_cur.st = pfc_pkg::PFC_CY_STROBE;
            next_cur.cnt = STROBE;
            // write: gate high, strobe low; read: gate low, strobe high
            next_cur.we = ~cur.wr;
            next_cur.oe = cur.wr;
         end
         pfc_pkg::PFC_CY_STROBE:
         begin
            if (cur.cnt <= 4'h1)
            begin
               next_cur.st = pfc_pkg::PFC_CY_HOLD;
               next_cur.we = 1'b1;
               next_cur.oe = 1'b1;
               next_cur.rd = byteLinesIn;
            end
            else
            begin
               next_cur.cnt = cur.cnt - 4'h1;
            end
         end
         pfc_pkg::PFC_CY_HOLD:
         begin
            // deselect between cycles so toggle bit advances
            next_cur.st = pfc_pkg::PFC_CY_IDLE;
            next_cur.cs = 1'b1;
            next_cur.ben = 1'b0;
            next_cur.done = 1'b1;
         end
         default:
         begin
            next_cur.st = pfc_pkg::PFC_CY_IDLE;
         end
      endcase
   end
   // registered state, synchronous reset to idle bus
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         cur <= '{st: pfc_pkg::PFC_CY_IDLE, cnt: 4'h0, wr: 1'b0,
                  done: 1'b0, rd: 8'h00, cs: 1'b1, oe: 1'b1, we: 1'b1,
                  a: 19'h00000, d: 8'h00, ben: 1'b0};
      end
      else if (clockEnable)
      begin
         cur <= next_cur;
      end
   end
   assign busy = (cur.st != pfc_pkg::PFC_CY_IDLE);
   assign done = cur.done;
   assign readByte = cur.rd;
   assign chipSelectN = cur.cs;
   assign outGateN = cur.oe;
   assign writeStrobeN = cur.we;
   assign address = cur.a;
   assign byteLinesOut = cur.d;
   // output enable is low while the controller drives
   assign byteLinesOe = ~cur.ben;
   // never drive the lines while the gate asks the device to drive
   a_no_contention: assert property (@(posedge clock)
      disable iff (reset) !outGateN |-> byteLinesOe)
      else $error("drive during read");
   // strobe low only with select low and gate high
   a_write_gate: assert property (@(posedge clock)
      disable iff (reset) !writeStrobeN |-> (!chipSelectN && outGateN))
      else $error("bad write strobe");
   // deselected: both strobes idle and the lines released
   a_idle_release: assert property (@(posedge clock)
      disable iff (reset)
      chipSelectN |-> (outGateN && writeStrobeN && byteLinesOe))
      else $error("pins active while deselected");
endmodule

// *** logic/pfc_host.sv ***
// apb controlled host that drives command sequences into a flash
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`include "pfc_cfg.svh"
// Operation
// - identifier mode ends only on reset
// - program: two unlocks, A0H, then target
// - poll the address being programmed
// - chip erase: six writes ending 10H
// - sector erase: five writes then 30H
// - during erase only suspend or resume; host has neither and accepts any op once a sector erase is issued
module pfc_host
(
   input wire logic clock,
   input wire logic reset,
   input wire logic clockEnable,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic chipSelectN,
   output logic outGateN,
   output logic writeStrobeN,
   output logic [18:0] address,
   output logic idHighVoltage,
   input wire logic [7:0] byteLinesIn,
   output logic [7:0] byteLinesOut,
   output logic byteLinesOe
);
   // whole controller state
   typedef struct packed
   {
      pfc_pkg::pfc_sq_t st;
      pfc_pkg::pfc_op_t op;
      logic [2:0] step; // index of the write in the sequence
      logic [18:0] tgtAddr, cyA; // software target, cycle address
      logic [7:0] tgtData, rdat, prevRead, cyD; // data and poll history
      logic busy, done, err, hv, firstPoll, start, isWr, pready, pslverr;
      logic [15:0] polls; // polls so far, bounded
      logic [31:0] prdata;
   } pfc_st_t;
   pfc_st_t cur, next_cur;
   // cycle engine wires
   logic cyBusy, cyDone;
   logic [7:0] cyRead;
   pfc_bus_cycle pfc_bus_cycle_i
   (
      .clock(clock), .reset(reset), .clockEnable(clockEnable),
      .start(cur.start), .isWrite(cur.isWr), .addrIn(cur.cyA),
      .dataIn(cur.cyD), .byteLinesIn(byteLinesIn), .busy(cyBusy),
      .done(cyDone), .readByte(cyRead), .chipSelectN(chipSelectN),
      .outGateN(outGateN), .writeStrobeN(writeStrobeN),
      .address(address), .byteLinesOut(byteLinesOut),
      .byteLinesOe(byteLinesOe)
   );
   // ---------------------------------------------------------------
   // sequence table: address and data of each write
   // ---------------------------------------------------------------
   // unlocks use the low-address form; upper bits are don't care
   function automatic logic [26:0] seqWord(input pfc_pkg::pfc_op_t op,
      input logic [2:0] step, input logic [18:0] ta, input logic [7:0] td);
      logic [26:0] w;
      w = {`PFC_UNLOCK_A1, `PFC_UNLOCK_D1};
      if (op == pfc_pkg::PFC_OP_RESET)
         w = {`PFC_UNLOCK_A1, `PFC_CMD_RESET};
      else if (op == pfc_pkg::PFC_OP_ADDSECTOR)
         w = {ta, `PFC_CMD_SECTOR};
      else if (step == 3'h1 || step == 3'h4)
         w = {`PFC_UNLOCK_A2, `PFC_UNLOCK_D2};
      else if (step == 3'h2)
      begin
         if (op == pfc_pkg::PFC_OP_PROGRAM)
            w = {`PFC_UNLOCK_A1, `PFC_CMD_PROGRAM};
         else if (op == pfc_pkg::PFC_OP_IDREAD)
            w = {`PFC_UNLOCK_A1, `PFC_CMD_AUTOSEL};
         else
            w = {`PFC_UNLOCK_A1, `PFC_CMD_ERASE};
      end
      else if (step == 3'h3 && op == pfc_pkg::PFC_OP_PROGRAM)
         w = {ta, td};
      else if (step == 3'h5)
      begin
         if (op == pfc_pkg::PFC_OP_SECTERASE)
            w = {ta, `PFC_CMD_SECTOR};
         else
            w = {`PFC_UNLOCK_A1, `PFC_CMD_CHIP};
      end
      return w;
   endfunction
   // index of the last write in each sequence (one less than its number of writes)
   function automatic logic [2:0] seqLast(input pfc_pkg::pfc_op_t op);
      case (op)
         pfc_pkg::PFC_OP_RESET, pfc_pkg::PFC_OP_ADDSECTOR: seqLast = 3'h0;
         pfc_pkg::PFC_OP_PROGRAM: seqLast = 3'h3;
         pfc_pkg::PFC_OP_IDREAD: seqLast = 3'h2;
         default: seqLast = 3'h5;
      endcase
   endfunction
   // ---------------------------------------------------------------
   // apb slave and command walker
   // ---------------------------------------------------------------
   always_comb
   begin
      logic [26:0] w;
      logic [7:0] diff;
      w = seqWord(cur.op, cur.step, cur.tgtAddr, cur.tgtData);
      diff = cyRead ^ cur.prevRead;
      next_cur = cur;
      next_cur.start = 1'b0;
      next_cur.pready = 1'b0;
      next_cur.pslverr = 1'b0;
      // apb: answer one cycle after setup, in the access phase
      if (psel && !penable)
      begin
         next_cur.pready = 1'b1;
         next_cur.prdata = 32'h00000000;
         if (pwrite)
         begin
            case (paddr)
               `PFC_OFF_CTRL:
               begin
                  next_cur.hv = pwdata[`PFC_CTRL_HV_BIT];
                  // go is refused while a sequence runs
                  if (pwdata[`PFC_CTRL_GO_BIT] && !cur.busy)
                  begin
                     next_cur.op = pfc_pkg::pfc_op_t'(pwdata[2:0]);
                     next_cur.st = pfc_pkg::PFC_SQ_ISSUE;
                     next_cur.step = 3'h0;
                     next_cur.busy = 1'b1;
                     next_cur.done = 1'b0;
                     next_cur.err = 1'b0;
                     next_cur.firstPoll = 1'b1;
                     next_cur.polls = 16'h0000;
                  end
               end
               `PFC_OFF_ADDR: next_cur.tgtAddr = pwdata[18:0];
               `PFC_OFF_DATA: next_cur.tgtData = pwdata[7:0];
               default: next_cur.pslverr = 1'b1;
            endcase
         end
         else
         begin
            case (paddr)
               `PFC_OFF_CTRL: next_cur.prdata = {23'h0, cur.hv, 5'h0, cur.op};
               `PFC_OFF_ADDR: next_cur.prdata = {13'h0000, cur.tgtAddr};
               `PFC_OFF_DATA: next_cur.prdata = {24'h000000, cur.tgtData};
               `PFC_OFF_STAT: next_cur.prdata = {29'h00000000, cur.err,
                  cur.done, cur.busy};
               `PFC_OFF_RDAT: next_cur.prdata = {24'h000000, cur.rdat};
               default: next_cur.pslverr = 1'b1;
            endcase
         end
      end
      case (cur.st)
         pfc_pkg::PFC_SQ_IDLE:
         begin
         end
         pfc_pkg::PFC_SQ_ISSUE:
            if (!cyBusy)
            begin
               next_cur.start = 1'b1;
               // only a plain read is a read at the target; id read writes its unlock sequence
               next_cur.isWr = !(cur.op == pfc_pkg::PFC_OP_READ);
               next_cur.cyA = (cur.op == pfc_pkg::PFC_OP_READ) ?
                  cur.tgtAddr : w[26:8];
               next_cur.cyD = w[7:0];
               next_cur.st = pfc_pkg::PFC_SQ_WAIT;
            end
         pfc_pkg::PFC_SQ_WAIT:
         begin
            if (cyDone)
            begin
               if (cur.op == pfc_pkg::PFC_OP_READ)
               begin
                  next_cur.rdat = cyRead;
                  next_cur.st = pfc_pkg::PFC_SQ_IDLE;
                  next_cur.busy = 1'b0;
                  next_cur.done = 1'b1;
               end
               else if (cur.step != seqLast(cur.op))
               begin
                  next_cur.step = cur.step + 3'h1;
                  next_cur.st = pfc_pkg::PFC_SQ_ISSUE;
               end
               else if (cur.op == pfc_pkg::PFC_OP_PROGRAM ||
                        cur.op == pfc_pkg::PFC_OP_CHIPERASE)
                  next_cur.st = pfc_pkg::PFC_SQ_POLL;
               else
               begin
                  // reset, id entry, sector erase and sector adds end at once so
                  // software can add sectors inside the timeout
                  next_cur.st = pfc_pkg::PFC_SQ_IDLE;
                  next_cur.busy = 1'b0;
                  next_cur.done = 1'b1;
               end
            end
         end
         pfc_pkg::PFC_SQ_POLL:
            if (!cyBusy)
            begin
               // poll the target address the operation works on
               next_cur.start = 1'b1;
               next_cur.isWr = 1'b0;
               next_cur.cyA = cur.tgtAddr;
               next_cur.st = pfc_pkg::PFC_SQ_PWAIT;
            end
         pfc_pkg::PFC_SQ_PWAIT:
         begin
            if (cyDone)
            begin
               next_cur.prevRead = cyRead;
               next_cur.firstPoll = 1'b0;
               next_cur.polls = cur.polls + 16'h0001;
               next_cur.rdat = cyRead;
               // finished when bit six stops toggling
               if (!cur.firstPoll && !diff[`PFC_TOGGLE_BIT])
               begin
                  next_cur.st = pfc_pkg::PFC_SQ_IDLE;
                  next_cur.busy = 1'b0;
                  next_cur.done = 1'b1;
                  // program must show the value written on bit seven
                  if (cur.op == pfc_pkg::PFC_OP_PROGRAM)
                     next_cur.err = cyRead[`PFC_POLL_BIT] !=
                        cur.tgtData[`PFC_POLL_BIT];
                  else
                     next_cur.err = !cyRead[`PFC_POLL_BIT];
               end
               else if (cur.polls == `PFC_MAX_POLLS)
               begin
                  // limitation: gives up after a fixed number of polls
                  next_cur.st = pfc_pkg::PFC_SQ_IDLE;
                  next_cur.busy = 1'b0;
                  next_cur.err = 1'b1;
               end
               else
                  next_cur.st = pfc_pkg::PFC_SQ_POLL;
            end
         end
         default:
            next_cur.st = pfc_pkg::PFC_SQ_IDLE;
      endcase
   end
   // registered state; the flash itself powers up in array read
   always_ff @(posedge clock)
   begin
      if (reset)
         cur <= '0;
      else if (clockEnable)
         cur <= next_cur;
   end
   assign prdata = cur.prdata;
   assign pready = cur.pready;
   assign pslverr = cur.pslverr;
   assign idHighVoltage = cur.hv;
   // last write of a program carries target address and data
   a_prog_target: assert property (@(posedge clock)
      disable iff (reset) (cur.start && cur.step == 3'h3 &&
      cur.op == pfc_pkg::PFC_OP_PROGRAM && cur.st == pfc_pkg::PFC_SQ_WAIT)
      |-> (cur.cyA == cur.tgtAddr && cur.cyD == cur.tgtData))
      else $error("program target wrong");
   // polls go only to the target address
   a_poll_addr: assert property (@(posedge clock)
      disable iff (reset) (cur.start && cur.st == pfc_pkg::PFC_SQ_PWAIT) |->
      cur.cyA == cur.tgtAddr) else $error("poll address wrong");
   // apb answers exactly one cycle after setup
   a_apb_answer: assert property (@(posedge clock) disable iff (reset)
      (psel && !penable && clockEnable) |=> pready)
      else $error("apb answer late");
   c_program: cover property (@(posedge clock)
      cur.op == pfc_pkg::PFC_OP_PROGRAM && cur.done);
   c_chip: cover property (@(posedge clock)
      cur.op == pfc_pkg::PFC_OP_CHIPERASE && cur.done);
   c_sector: cover property (@(posedge clock)
      cur.op == pfc_pkg::PFC_OP_ADDSECTOR && cur.done);
endmodule

// *** bench/pfc_flash_model.sv ***
// behavioural model of the parallel flash seen from the host pins
`timescale 1ns/1ps
module pfc_flash_model
#(
   parameter logic [7:0] MAKER = 8'h5A, // arbitrary value
   parameter logic [7:0] PART = 8'hC3, // arbitrary value
   parameter int BUSY_READS = 5
)
(
   input wire logic chipSelectN,
   input wire logic outGateN,
   input wire logic writeStrobeN,
   input wire logic [18:0] address,
   input wire logic idHighVoltage,
   input wire logic [7:0] byteLinesOut,
   input wire logic byteLinesOe,
   output logic [7:0] byteLinesIn
);
   logic [7:0] mem [int]; // bytes never written read as erased
   logic [18:0] wa = 19'h00000; // address taken at strobe fall
   logic [7:0] rd = 8'h00; // byte offered on a read
   logic idMode = 1'b0; // power-up lands in array read
   logic isProg = 1'b0;
   logic tog = 1'b0;
   logic [7:0] lastD = 8'h00;
   int step = 0;
   int busy = 0; // embedded op lasts a few status reads
   int badPoll = 0; // program polls away from the target
   // released lines show the inverse, so a stale byte never looks valid
   assign byteLinesIn = (!chipSelectN && !outGateN && writeStrobeN) ? rd : ~rd;
   // address at falling strobe, data at rising strobe
   always @(negedge writeStrobeN)
      if (!chipSelectN)
         wa = address;
   always @(posedge writeStrobeN)
      if (!chipSelectN)
         command(wa, byteLinesOut);
   // drop every key that lies in the addressed 64K sector
   task automatic eraseSector(input logic [18:0] a);
      int ks[$];
      foreach (mem[k])
         if ((k >> 16) == a[18:16])
            ks.push_back(k);
      foreach (ks[i])
         mem.delete(ks[i]);
   endtask
   // command walker; upper address bits ignored in decode
   task automatic command(input logic [18:0] a, input logic [7:0] d);
      logic [14:0] c;
      c = a[14:0];
      if (busy > 0)
         return; // running op is never aborted
      if (d == 8'hF0 && step != 10)
      begin
         step = 0;
         idMode = 1'b0;
      end
      else if (step == 0 || step == 3)
         step = (c == 15'h5555 && d == 8'hAA) ? step + 1 : 0;
      else if (step == 1 || step == 4)
         step = (c == 15'h2AAA && d == 8'h55) ? step + 1 : 0;
      else if (step == 2)
      begin
         idMode = (c == 15'h5555 && d == 8'h90);
         step = (c != 15'h5555) ? 0 : (d == 8'hA0) ? 10 : (d == 8'h80) ? 3 : 0;
      end
      else if (step == 5 && c == 15'h5555 && d == 8'h10)
      begin
         mem.delete();
         isProg = 1'b0;
         busy = BUSY_READS;
         step = 0;
      end
      else if ((step == 5 || step == 6) && d == 8'h30)
      begin
         eraseSector(a);
         step = 6;
      end
      else if (step == 10)
      begin
         mem[a] = d;
         lastD = d;
         isProg = 1'b1;
         busy = BUSY_READS;
         step = 0;
      end
      else
         step = 0;
   endtask
   // each read start picks the byte: identifier, status or array
   always @(negedge outGateN)
      if (!chipSelectN && writeStrobeN)
      begin
         if (idMode || idHighVoltage)
            rd = (address[7:0] == 8'h00) ? MAKER :
               (address[7:0] == 8'h01) ? PART : 8'h00;
         else if (busy > 0)
         begin
            tog = ~tog;
            if (isProg && address != wa)
               badPoll++;
            rd = {isProg ? ~lastD[7] : 1'b0, tog, 6'h00};
            busy--;
         end
         else
            rd = mem.exists(address) ? mem[address] : 8'hFF;
      end
endmodule

// *** bench/tb_pfc_host.sv ***
// self-checking bench for the apb flash command controller
`timescale 1ns/1ps
`include "pfc_cfg.svh"
module tb_pfc_host;
   localparam logic [7:0] MAKER = 8'h5A; // arbitrary value
   localparam logic [7:0] PART = 8'hC3; // arbitrary value
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdVal;
   logic pready, pslverr, chipSelectN, outGateN, writeStrobeN;
   logic idHighVoltage, byteLinesOe;
   logic [18:0] address, pa;
   logic [7:0] byteLinesIn, byteLinesOut, pd;
   logic [31:0] lfsr = 32'hADBD;
   logic [64:0] expQ [$]; // {error flag, mask, value} per transfer
   logic [7:0] idByte [3] = '{MAKER, PART, 8'h00};
   logic [18:0] secAddr [3] = '{19'h3ABCD, 19'h51234, 19'h6F00F};
   int error_cnt = 0;
   int compares = 0;
   int cycles = 0;
   always #12.5 clock = ~clock;
   pfc_host pfc_host_i (.clock(clock), .reset(reset), .clockEnable(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chipSelectN(chipSelectN), .outGateN(outGateN),
      .writeStrobeN(writeStrobeN), .address(address),
      .idHighVoltage(idHighVoltage), .byteLinesIn(byteLinesIn),
      .byteLinesOut(byteLinesOut), .byteLinesOe(byteLinesOe));
   pfc_flash_model #(.MAKER(MAKER), .PART(PART)) pfc_flash_model_i (
      .chipSelectN(chipSelectN), .outGateN(outGateN),
      .writeStrobeN(writeStrobeN), .address(address),
      .idHighVoltage(idHighVoltage), .byteLinesOut(byteLinesOut),
      .byteLinesOe(byteLinesOe), .byteLinesIn(byteLinesIn));
   function automatic logic [31:0] nextLfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic end_of_test();
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // compare a finished transfer against the oldest note
   task automatic check(input logic [64:0] e);
      compares++;
      if (pslverr !== e[64] || ((prdata ^ e[31:0]) & e[63:32]) !== 32'h0)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h err %b", $time, prdata, pslverr);
      end
   endtask
   always @(posedge clock)
      if (pready === 1'b1)
         check(expQ.pop_front());
   // hang guard: runs far longer than the whole sequence needs
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         error_cnt++;
         end_of_test();
      end
   end
   // one apb transfer; request held until pready is seen
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, input logic [31:0] m, input logic er);
      expQ.push_back({er, m, d});
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rdVal = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdReg(input logic [11:0] a, input logic [31:0] v);
      apb(1'b0, a, v, 32'hFF, 1'b0);
   endtask
   // start an operation, then poll status until done or error shows
   task automatic run(input logic [2:0] op, input logic [18:0] a,
      input logic [7:0] d, input logic hv);
      apb(1'b1, `PFC_OFF_ADDR, {13'h0, a}, 32'h0, 1'b0);
      apb(1'b1, `PFC_OFF_DATA, {24'h0, d}, 32'h0, 1'b0);
      apb(1'b1, `PFC_OFF_CTRL, {1'b1, 22'h0, hv, 5'h0, op}, 32'h0, 1'b0);
      do apb(1'b0, `PFC_OFF_STAT, 32'h0, 32'h0, 1'b0);
      while (rdVal[2:1] === 2'b00);
      apb(1'b0, `PFC_OFF_STAT, 32'h2, 32'h6, 1'b0);
   endtask
   initial
   begin
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      apb(1'b0, `PFC_OFF_STAT, 32'h0, 32'h7, 1'b0);
      apb(1'b0, 12'h020, 32'h0, 32'h0, 1'b1); // unmapped offset
      for (int i = 0; i < 3; i++)
      begin
         lfsr = nextLfsr(lfsr);
         pa = lfsr[18:0];
         pd = lfsr[26:19];
         run(3'h3, pa, pd, 1'b0);
         run(3'h0, pa, 8'h00, 1'b0);
         rdReg(`PFC_OFF_RDAT, {24'h0, pd});
      end
      run(3'h4, 19'h05555, 8'h00, 1'b0);
      run(3'h0, pa, 8'h00, 1'b0);
      rdReg(`PFC_OFF_RDAT, 32'hFF);
      run(3'h2, 19'h00000, 8'h00, 1'b0);
      for (int k = 0; k < 3; k++)
      begin
         run(3'h0, 19'h30000 | k, 8'h00, 1'b0);
         rdReg(`PFC_OFF_RDAT, {24'h0, idByte[k]});
      end
      run(3'h1, 19'h00000, 8'h00, 1'b0);
      run(3'h0, 19'h00000, 8'h00, 1'b0);
      rdReg(`PFC_OFF_RDAT, 32'hFF);
      run(3'h0, 19'h00001, 8'h00, 1'b1);
      rdReg(`PFC_OFF_RDAT, {24'h0, PART});
      for (int k = 0; k < 3; k++)
         run(3'h3, secAddr[k], 8'h3C, 1'b0);
      run(3'h5, secAddr[0], 8'h00, 1'b0);
      run(3'h6, secAddr[1], 8'h00, 1'b0);
      run(3'h1, 19'h00000, 8'h00, 1'b0);
      run(3'h6, secAddr[2], 8'h00, 1'b0);
      for (int k = 0; k < 3; k++)
      begin
         run(3'h0, secAddr[k], 8'h00, 1'b0);
         rdReg(`PFC_OFF_RDAT, (k < 2) ? 32'hFF : 32'h3C);
      end
      compares++;
      if (pfc_flash_model_i.badPoll != 0)
      begin
         error_cnt++;
         $display("wrong value at %0t: polls off target", $time);
      end
      end_of_test();
   end
endmodule
